// >>> dv/lad_decode_test.sv
`timescale 1ns/1ps
module lad_decode_test;
    logic clk_sys_i = 1'b0, rst_i = 1'b1, io_wr_i = 1'b0, io_rd_i = 1'b0;
    logic [15:0] io_port_i = 16'h0;
    logic [7:0]  io_wdata_i = 8'h0, io_rdata_o, attr_map_i = 8'h0;
    logic [1:0]  gfx_mem_sel_i = 2'h1;
    logic system_management_ram_control_open_i = 1'b0, system_management_ram_control_smm_en_i = 1'b0, cd_hole_enable_i = 1'b0;
    logic req_valid_i, req_write_i, req_io_i, req_src_hub_i, req_smm_i;
    logic [35:0] req_addr_i;
    logic io_rvalid_o, rsp_valid_o, rsp_rd_zero_o, rsp_src_hub_o;
    logic packed_mode_o, linear_map_o;
    lad_pkg::lad_route_t rsp_route_o;
    lad_pkg::lad_gtgt_t  rsp_gfx_tgt_o;
    logic [23:0] rsp_xlat_o;
    int failures = 0, n_tests = 0, cyc = 0;
    logic [35:0] va [3] = '{36'hA0000, 36'hB7FFF, 36'hB8000};
    logic [2:0]  hit [4] = '{3'b111, 3'b100, 3'b010, 3'b001};

    always #2.5 clk_sys_i = ~clk_sys_i;

    lad_decode dut (.clk_sys_i, .rst_i, .io_wr_i, .io_rd_i, .io_port_i,
        .io_wdata_i, .io_rdata_o, .io_rvalid_o, .req_valid_i, .req_addr_i,
        .req_write_i, .req_io_i, .req_src_hub_i, .req_smm_i, .gfx_mem_sel_i,
        .system_management_ram_control_open_i, .system_management_ram_control_smm_en_i, .cd_hole_enable_i, .attr_map_i,
        .rsp_valid_o, .rsp_route_o, .rsp_gfx_tgt_o, .rsp_xlat_o,
        .rsp_rd_zero_o, .rsp_src_hub_o, .packed_mode_o, .linear_map_o);

    lad_host_init host (.clk_sys_i, .req_valid_o(req_valid_i),
        .req_addr_o(req_addr_i), .req_write_o(req_write_i),
        .req_io_o(req_io_i), .req_src_hub_o(req_src_hub_i),
        .req_smm_o(req_smm_i));

    task automatic finish_test;
        $display("failures=%0d n_tests=%0d", failures, n_tests);
        if (failures == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string n, input logic [23:0] e, g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [15:0] p, input logic [7:0] d);
        @(negedge clk_sys_i);
        {io_port_i, io_wdata_i, io_wr_i} = {p, d, 1'b1};
        @(negedge clk_sys_i);
        io_wr_i = 1'b0;
    endtask

    // Index then data back to back, strobe held high between them
    task automatic gr(input logic [7:0] i, d);
        @(negedge clk_sys_i);
        {io_port_i, io_wdata_i, io_wr_i} = {16'h03CE, i, 1'b1};
        @(negedge clk_sys_i);
        {io_port_i, io_wdata_i} = {16'h03CF, d};
        @(negedge clk_sys_i);
        io_wr_i = 1'b0;
    endtask

    task automatic rd(input logic [15:0] p, input logic [7:0] e);
        @(negedge clk_sys_i);
        {io_port_i, io_rd_i} = {p, 1'b1};
        @(negedge clk_sys_i);
        io_rd_i = 1'b0;
        chk("rvalid", 24'h1, {23'h0, io_rvalid_o});
        chk("rdata", {16'h0, e}, {16'h0, io_rdata_o});
    endtask

    // Tgt of zero means the target field is not compared
    task automatic dec(input logic [35:0] a, input logic [3:0] f,
                       input logic [4:0] r, input logic [3:0] t);
        host.send(a, f);
        chk("rsp_valid", 24'h1, {23'h0, rsp_valid_o});
        chk("route", {19'h0, r}, {19'h0, rsp_route_o});
        if (t != 4'h0)
            chk("tgt", {20'h0, t}, {20'h0, rsp_gfx_tgt_o});
    endtask

    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 4000) begin
            failures++;
            finish_test();
        end
    end

    initial begin
        repeat (8) @(negedge clk_sys_i);
        rst_i = 1'b0;
        wr(16'h03CE, 8'h10);
        rd(16'h03CF, 8'h00);
        chk("packed", 24'h0, {23'h0, packed_mode_o});
        wr(16'h03CE, 8'h11);
        rd(16'h03CF, 8'h00);
        rd(16'h03CE, 8'h01);
        wr(16'h03C2, 8'h02);
        rd(16'h03CC, 8'h02);
        for (int m = 0; m < 4; m++) begin
            gr(8'h06, 8'(m << 2));
            for (int k = 0; k < 3; k++)
                dec(va[k], 4'h0, hit[m][2-k] ? 5'h04 : 5'h02,
                    hit[m][2-k] ? 4'h2 : 4'h0);
        end
        wr(16'h03C2, 8'h00);
        dec(36'hB8000, 4'h0, 5'h02, 4'h0);
        wr(16'h03C2, 8'h02);
        dec(36'hB8000, 4'h2, 5'h04, 4'h2);
        chk("src_hub", 24'h1, {23'h0, rsp_src_hub_o});
        system_management_ram_control_smm_en_i = 1'b1;
        dec(36'hB8000, 4'h1, 5'h01, 4'h0);
        system_management_ram_control_smm_en_i = 1'b0;
        gr(8'h10, 8'h08);
        dec(36'hB8000, 4'h0, 5'h04, 4'h8);
        gr(8'h11, 8'h5A);
        gr(8'h10, 8'h11);
        dec(36'hAFFFF, 4'h0, 5'h04, 4'h4);
        chk("xlat", 24'h5AFFFF, rsp_xlat_o);
        dec(36'hB0000, 4'h0, 5'h02, 4'h0);
        gr(8'h10, 8'h01);
        dec(36'hA1234, 4'h0, 5'h04, 4'h2);
        gr(8'h10, 8'hFF);
        rd(16'h03CF, 8'h1F);
        chk("linear", 24'h3, {22'h0, packed_mode_o, linear_map_o});
        gr(8'h06, 8'hFF);
        rd(16'h03CF, 8'h0C);
        wr(16'h03CE, 8'hFF);
        rd(16'h03CE, 8'h0F);
        dec(36'h9FFFF, 4'h0, 5'h01, 4'h0);
        chk("src_hub", 24'h0, {23'h0, rsp_src_hub_o});
        dec(36'h100000000, 4'h0, 5'h08, 4'h0);
        chk("rd_zero", 24'h1, {23'h0, rsp_rd_zero_o});
        dec(36'h100000000, 4'h8, 5'h08, 4'h0);
        chk("rd_zero", 24'h0, {23'h0, rsp_rd_zero_o});
        dec(36'hFFFFFFFF, 4'h0, 5'h10, 4'h0);
        dec(36'h003CE, 4'h4, 5'h04, 4'h0);
        dec(36'h103CE, 4'h4, 5'h02, 4'h0);
        cd_hole_enable_i = 1'b1;
        attr_map_i = 8'hFF;
        dec(36'hDC000, 4'h0, 5'h02, 4'h0);
        dec(36'hB8000, 4'h0, 5'h04, 4'h0);
        cd_hole_enable_i = 1'b0;
        attr_map_i = 8'h04;
        dec(36'hDFFFF, 4'h0, 5'h01, 4'h0);
        dec(36'hDFFFF, 4'h8, 5'h02, 4'h0);
        attr_map_i = 8'h42;
        dec(36'hC0000, 4'h8, 5'h01, 4'h0);
        dec(36'hC0000, 4'h0, 5'h02, 4'h0);
        dec(36'hFFFFF, 4'h0, 5'h01, 4'h0);
        dec(36'hFFFFF, 4'h8, 5'h02, 4'h0);
        dec(36'hD0000, 4'h0, 5'h02, 4'h0);
        finish_test();
    end
endmodule // lad_decode_test

// >>> dv/lad_host_init.sv
`timescale 1ns/1ps
module lad_host_init (
    // Clock
    input  wire logic        clk_sys_i,
    // Request toward the decoder
    output logic             req_valid_o,
    output logic      [35:0] req_addr_o,
    output logic             req_write_o,
    output logic             req_io_o,
    output logic             req_src_hub_o,
    output logic             req_smm_o
);
    initial begin
        req_valid_o = 1'b0;
        req_addr_o  = 36'h0;
        {req_write_o, req_io_o, req_src_hub_o, req_smm_o} = 4'h0;
    end

    // Flags are write, io, hub, smm, from the most significant bit down
    task automatic send(input logic [35:0] a, input logic [3:0] f);
        @(negedge clk_sys_i);
        {req_write_o, req_io_o, req_src_hub_o, req_smm_o} = f;
        req_addr_o  = a;
        req_valid_o = 1'b1;
        @(negedge clk_sys_i);
        // Idle lines show inverted address, never a stale copy
        req_valid_o = 1'b0;
        req_addr_o  = ~a;
    endtask
endmodule // lad_host_init

// >>> logic/lad_cfg_if.sv
`timescale 1ns/1ps
interface lad_cfg_if;
    logic [1:0]               map_mode;
    logic [lad_pkg::AM_W-1:0] addr_map;
    logic [7:0]               page_sel;
    logic                     legacy_en;

    modport src (output map_mode, output addr_map, output page_sel,
                 output legacy_en);
    modport dst (input map_mode, input addr_map, input page_sel,
                 input legacy_en);
endinterface

// >>> logic/lad_decode.sv
`timescale 1ns/1ps
// Operation
// - Map mode bits 3:2 pick full, A-segment, mono or colour-text window.
// - Map mode window applies in standard and non-linear extended modes; the code applies it in linear mode too.
// - Address mapping bit 4 pages to VGA buffer or display cache.
// - Address mapping bit 3 picks VGA buffer or memory map; resets to buffer.
// - Packed mode and linear mapping enables reset off; setting enables them.
// - Page mapping enable maps memory through 64 KB A0000-AFFFF window.
// - Page select picks the 64 KB display cache page shown.
// - Registers sit behind the data port at index 06h, 10h, 11h.
// - Accesses above 4 GB are claimed, writes dropped, reads return zero.
// - Decoder spans 4 GB memory and 64 KB plus three I/O bytes.
// - Lowest 640 KB always goes to main memory.
// - Video region goes to hub or graphics, or to main memory on an SMM hit, ignoring shadow attributes.
// - Video region is default SMM space, steered by SYSTEM_MANAGEMENT_RAM_CONTROL control.
// - Video steering applies to host bus and hub initiators alike.
// - CD hole enabled forwards the hole to the hub, ignoring attributes.
// - CD hole disabled follows attribute map bits 3:2.
// - Four 64 KB shadow segments have independent read and write enables.
// - Compatibility ranges default to hub; only VGA may go to graphics.
// - Index register holds five bits; only the low four read back, upper four read zero.
// - Legacy access enable gates graphics claiming of the video window.
module lad_decode (
    // Clock and reset
    input  wire logic               clk_sys_i,
    input  wire logic               rst_i,
    // Graphics register port
    input  wire logic               io_wr_i,
    input  wire logic               io_rd_i,
    input  wire logic [15:0]        io_port_i,
    input  wire logic [7:0]         io_wdata_i,
    output logic      [7:0]         io_rdata_o,
    output logic                    io_rvalid_o,
    // Access request
    input  wire logic               req_valid_i,
    input  wire logic [35:0]        req_addr_i,
    input  wire logic               req_write_i,
    input  wire logic               req_io_i,
    input  wire logic               req_src_hub_i,
    input  wire logic               req_smm_i,
    // System configuration
    input  wire logic [1:0]         gfx_mem_sel_i,
    input  wire logic               system_management_ram_control_open_i,
    input  wire logic               system_management_ram_control_smm_en_i,
    input  wire logic               cd_hole_enable_i,
    input  wire logic [7:0]         attr_map_i,
    // Decode result
    output logic                    rsp_valid_o,
    output lad_pkg::lad_route_t     rsp_route_o,
    output lad_pkg::lad_gtgt_t      rsp_gfx_tgt_o,
    output logic      [23:0]        rsp_xlat_o,
    output logic                    rsp_rd_zero_o,
    output logic                    rsp_src_hub_o,
    output logic                    packed_mode_o,
    output logic                    linear_map_o
);
    typedef struct packed {
        logic                vld;
        lad_pkg::lad_route_t route;
        lad_pkg::lad_gtgt_t  tgt;
        logic [23:0]         xlat;
        logic                rd_zero;
        logic                src_hub;
        logic                packed_m;
        logic                linear;
    } lad_top_st_t;

    lad_top_st_t st_q;
    lad_top_st_t st_d;

    lad_cfg_if cfg_if ();

    lad_vga_regs u_regs (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .io_wr_i     (io_wr_i),
        .io_rd_i     (io_rd_i),
        .io_port_i   (io_port_i),
        .io_wdata_i  (io_wdata_i),
        .io_rdata_o  (io_rdata_o),
        .io_rvalid_o (io_rvalid_o),
        .cfg         (cfg_if.src)
    );

    logic        compat;
    logic        above_4g;
    logic [19:0] low_addr;
    logic        low_mem_hit;
    logic        vid_hit;
    logic        aseg_hit;
    logic        mono_hit;
    logic        ctxt_hit;
    logic        cd_hit;
    logic [lad_pkg::SEG_NUM-1:0] seg_hit;
    logic        map_hit;
    logic        gfx_ok;
    logic        smm_hit;
    logic        io_gfx_port;
    logic [1:0]  seg_attr;
    logic [1:0]  cd_attr;

    assign above_4g = |req_addr_i[35:32];
    assign compat   = !req_io_i && (req_addr_i[35:20] == 16'h0000);
    assign low_addr = req_addr_i[19:0];

    lad_range_hit #(.LO(lad_pkg::LOW_MEM_LO), .HI(lad_pkg::LOW_MEM_HI)) u_low (
        .en_i (compat), .addr_i (low_addr), .hit_o (low_mem_hit));
    lad_range_hit #(.LO(lad_pkg::VID_LO), .HI(lad_pkg::VID_HI)) u_vid (
        .en_i (compat), .addr_i (low_addr), .hit_o (vid_hit));
    lad_range_hit #(.LO(lad_pkg::VID_LO), .HI(lad_pkg::ASEG_HI)) u_aseg (
        .en_i (compat), .addr_i (low_addr), .hit_o (aseg_hit));
    lad_range_hit #(.LO(lad_pkg::MONO_LO), .HI(lad_pkg::MONO_HI)) u_mono (
        .en_i (compat), .addr_i (low_addr), .hit_o (mono_hit));
    lad_range_hit #(.LO(lad_pkg::CTXT_LO), .HI(lad_pkg::VID_HI)) u_ctxt (
        .en_i (compat), .addr_i (low_addr), .hit_o (ctxt_hit));
    lad_range_hit #(.LO(lad_pkg::CD_LO), .HI(lad_pkg::CD_HI)) u_cd (
        .en_i (compat), .addr_i (low_addr), .hit_o (cd_hit));

    for (genvar g = 0; g < lad_pkg::SEG_NUM; g++) begin : g_seg
        lad_range_hit #(
            .LO (20'(lad_pkg::SEG_BASE + 20'(g) * lad_pkg::SEG_SPAN)),
            .HI (20'(lad_pkg::SEG_BASE + 20'(g + 1) * lad_pkg::SEG_SPAN
                     - 20'h00001))
        ) u_hit (
            .en_i   (compat),
            .addr_i (low_addr),
            .hit_o  (seg_hit[g])
        );
    end

    // Window chosen by the memory map mode, linear mode or not
    always_comb begin
        case (cfg_if.map_mode)
            lad_pkg::MODE_FULL: map_hit = vid_hit;
            lad_pkg::MODE_ASEG: map_hit = aseg_hit;
            lad_pkg::MODE_MONO: map_hit = mono_hit;
            default:            map_hit = ctxt_hit;
        endcase
    end

    // Graphics claims video memory only when enabled and legacy access is allowed
    assign gfx_ok      = (gfx_mem_sel_i != 2'h0) && cfg_if.legacy_en;
    assign smm_hit     = system_management_ram_control_open_i ||
                         (req_smm_i && system_management_ram_control_smm_en_i);
    assign seg_attr    = attr_map_i[{low_addr[17:16], 1'b0} +: 2];
    assign cd_attr     = attr_map_i[lad_pkg::ATTR_CD_LSB +: 2];
    // Upper three wrap-around I/O bytes never hit the graphics ports
    assign io_gfx_port = !req_addr_i[16] &&
        ((req_addr_i[15:0] == lad_pkg::IO_GFX_INDEX) ||
         (req_addr_i[15:0] == lad_pkg::IO_GFX_DATA)  ||
         (req_addr_i[15:0] == lad_pkg::IO_MISC_WR)   ||
         (req_addr_i[15:0] == lad_pkg::IO_MISC_RD));

    // Overlapping ranges are resolved only by this fixed priority
    always_comb begin
        st_d          = st_q;
        st_d.vld      = req_valid_i;
        st_d.packed_m = cfg_if.addr_map[lad_pkg::AM_PACKED];
        st_d.linear   = cfg_if.addr_map[lad_pkg::AM_LINEAR];
        if (req_valid_i) begin
            st_d.route   = lad_pkg::RT_HUB;
            st_d.tgt     = lad_pkg::GT_NONE;
            st_d.xlat    = req_addr_i[23:0];
            st_d.rd_zero = 1'b0;
            st_d.src_hub = req_src_hub_i;
            if (req_io_i) begin
                if (io_gfx_port) begin
                    st_d.route = lad_pkg::RT_GFX;
                end
            end else if (above_4g) begin
                st_d.route   = lad_pkg::RT_ABORT;
                st_d.rd_zero = !req_write_i;
            end else if (!compat) begin
                st_d.route = lad_pkg::RT_EXT;
            end else if (low_mem_hit) begin
                st_d.route = lad_pkg::RT_DRAM;
            end else if (vid_hit) begin
                if (smm_hit) begin
                    st_d.route = lad_pkg::RT_DRAM;
                end else if (cfg_if.addr_map[lad_pkg::AM_PAGE_EN] &&
                             aseg_hit && gfx_ok) begin
                    st_d.route = lad_pkg::RT_GFX;
                    if (cfg_if.addr_map[lad_pkg::AM_PAGE_DC]) begin
                        st_d.tgt  = lad_pkg::GT_DCACHE;
                        st_d.xlat = {cfg_if.page_sel, low_addr[15:0]};
                    end else begin
                        st_d.tgt  = lad_pkg::GT_VGA;
                    end
                end else if (map_hit && gfx_ok) begin
                    st_d.route = lad_pkg::RT_GFX;
                    st_d.tgt   = cfg_if.addr_map[lad_pkg::AM_MMAP] ?
                                 lad_pkg::GT_MMAP : lad_pkg::GT_VGA;
                end
            end else if (cd_hit && cd_hole_enable_i) begin
                st_d.route = lad_pkg::RT_HUB;
            end else if (cd_hit) begin
                if (req_write_i ? cd_attr[lad_pkg::ATTR_WE]
                                : cd_attr[lad_pkg::ATTR_RE]) begin
                    st_d.route = lad_pkg::RT_DRAM;
                end
            end else if (|seg_hit) begin
                if (req_write_i ? seg_attr[lad_pkg::ATTR_WE]
                                : seg_attr[lad_pkg::ATTR_RE]) begin
                    st_d.route = lad_pkg::RT_DRAM;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rsp_valid_o   = st_q.vld;
    assign rsp_route_o   = st_q.route;
    assign rsp_gfx_tgt_o = st_q.tgt;
    assign rsp_xlat_o    = st_q.xlat;
    assign rsp_rd_zero_o = st_q.rd_zero;
    assign rsp_src_hub_o = st_q.src_hub;
    assign packed_mode_o = st_q.packed_m;
    assign linear_map_o  = st_q.linear;

    property p_low_mem;
        @(posedge clk_sys_i) disable iff (rst_i)
        req_valid_i && compat && (low_addr <= lad_pkg::LOW_MEM_HI)
        |=> rsp_valid_o && (rsp_route_o == lad_pkg::RT_DRAM);
    endproperty
    a_low_mem: assert property (p_low_mem)
        else $error("low 640 KB not routed to main memory");

    property p_above_4g;
        @(posedge clk_sys_i) disable iff (rst_i)
        req_valid_i && !req_io_i && (req_addr_i[35:32] != 4'h0)
        |=> (rsp_route_o == lad_pkg::RT_ABORT)
            && (rsp_rd_zero_o == !$past(req_write_i));
    endproperty
    a_above_4g: assert property (p_above_4g)
        else $error("access above 4 GB not terminated");

    property p_cd_hole_on;
        @(posedge clk_sys_i) disable iff (rst_i)
        req_valid_i && compat && cd_hole_enable_i
        && (low_addr >= lad_pkg::CD_LO) && (low_addr <= lad_pkg::CD_HI)
        |=> rsp_route_o == lad_pkg::RT_HUB;
    endproperty
    a_cd_hole_on: assert property (p_cd_hole_on)
        else $error("enabled CD hole not sent to hub");

    property p_cd_hole_attr;
        @(posedge clk_sys_i) disable iff (rst_i)
        req_valid_i && compat && !cd_hole_enable_i && !req_write_i
        && (low_addr >= lad_pkg::CD_LO) && (low_addr <= lad_pkg::CD_HI)
        |=> (rsp_route_o == lad_pkg::RT_DRAM) == $past(attr_map_i[2]);
    endproperty
    a_cd_hole_attr: assert property (p_cd_hole_attr)
        else $error("CD hole read ignores attribute bits");

    property p_shadow_wr;
        @(posedge clk_sys_i) disable iff (rst_i)
        req_valid_i && compat && req_write_i
        && (low_addr[19:16] == 4'hC)
        |=> (rsp_route_o == lad_pkg::RT_DRAM) == $past(attr_map_i[1]);
    endproperty
    a_shadow_wr: assert property (p_shadow_wr)
        else $error("shadow write enable not honoured");

    property p_page_dc;
        @(posedge clk_sys_i) disable iff (rst_i)
        req_valid_i && aseg_hit && gfx_ok && !smm_hit
        && cfg_if.addr_map[lad_pkg::AM_PAGE_EN]
        && cfg_if.addr_map[lad_pkg::AM_PAGE_DC]
        |=> (rsp_route_o == lad_pkg::RT_GFX)
            && (rsp_gfx_tgt_o == lad_pkg::GT_DCACHE)
            && (rsp_xlat_o[23:16] == $past(cfg_if.page_sel));
    endproperty
    a_page_dc: assert property (p_page_dc)
        else $error("paged window does not select display cache page");

    property p_legacy_off;
        @(posedge clk_sys_i) disable iff (rst_i)
        req_valid_i && vid_hit && !cfg_if.legacy_en
        |=> rsp_route_o != lad_pkg::RT_GFX;
    endproperty
    a_legacy_off: assert property (p_legacy_off)
        else $error("video window claimed with legacy access off");

    property p_mode_aseg;
        @(posedge clk_sys_i) disable iff (rst_i)
        req_valid_i && mono_hit && !smm_hit
        && (cfg_if.map_mode == lad_pkg::MODE_ASEG)
        |=> rsp_route_o == lad_pkg::RT_HUB;
    endproperty
    a_mode_aseg: assert property (p_mode_aseg)
        else $error("B segment claimed in A-segment map mode");

    property p_idx_read;
        @(posedge clk_sys_i) disable iff (rst_i)
        io_rd_i && !io_wr_i && (io_port_i == lad_pkg::IO_GFX_INDEX)
        |=> io_rvalid_o && (io_rdata_o[7:4] == 4'h0);
    endproperty
    a_idx_read: assert property (p_idx_read)
        else $error("index read upper bits not zero");

    property p_amap_write;
        @(posedge clk_sys_i) disable iff (rst_i)
        io_wr_i && (io_port_i == lad_pkg::IO_GFX_INDEX)
        && (io_wdata_i == 8'h10)
        ##1 io_wr_i && (io_port_i == lad_pkg::IO_GFX_DATA)
        |=> cfg_if.addr_map == $past(io_wdata_i[4:0]);
    endproperty
    a_amap_write: assert property (p_amap_write)
        else $error("address mapping write through data port lost");

    property p_amap_reset;
        @(posedge clk_sys_i) disable iff (rst_i)
        $fell(rst_i) |-> (cfg_if.addr_map == 5'h00) && !linear_map_o;
    endproperty
    a_amap_reset: assert property (p_amap_reset)
        else $error("address mapping not cleared by reset");
endmodule // lad_decode

// >>> logic/lad_pkg.sv
package lad_pkg;

    // Graphics register ports in I/O space
    localparam logic [15:0] IO_GFX_INDEX   = 16'h03CE;
    localparam logic [15:0] IO_GFX_DATA    = 16'h03CF;
    localparam logic [15:0] IO_MISC_WR     = 16'h03C2;
    localparam logic [15:0] IO_MISC_RD     = 16'h03CC;

    // Indexed registers behind the data port
    localparam int          IDX_W          = 5;
    localparam logic [4:0]  IDX_MISC       = 5'h06;
    localparam logic [4:0]  IDX_ADDR_MAP   = 5'h10;
    localparam logic [4:0]  IDX_PAGE       = 5'h11;
    localparam int          IDX_READ_W     = 4;

    // Field positions
    localparam int          MISC_MODE_LSB  = 2;
    localparam int          AM_W           = 5;
    localparam int          AM_PAGE_DC     = 4;
    localparam int          AM_MMAP        = 3;
    localparam int          AM_PACKED      = 2;
    localparam int          AM_LINEAR      = 1;
    localparam int          AM_PAGE_EN     = 0;
    localparam int          LEGACY_EN_BIT  = 1;
    localparam int          ATTR_RE        = 0;
    localparam int          ATTR_WE        = 1;
    localparam int          ATTR_CD_LSB    = 2;

    // Values after reset
    localparam logic [4:0]  IDX_RST        = 5'h00;
    localparam logic [1:0]  MODE_RST       = 2'h0;
    localparam logic [4:0]  AM_RST         = 5'h00;
    localparam logic [7:0]  PAGE_RST       = 8'h00;
    localparam logic        LEGACY_RST     = 1'b0;

    // Memory map modes
    localparam logic [1:0]  MODE_FULL      = 2'h0;
    localparam logic [1:0]  MODE_ASEG      = 2'h1;
    localparam logic [1:0]  MODE_MONO      = 2'h2;

    // Compatibility area ranges
    localparam logic [19:0] LOW_MEM_LO     = 20'h00000;
    localparam logic [19:0] LOW_MEM_HI     = 20'h9FFFF;
    localparam logic [19:0] VID_LO         = 20'hA0000;
    localparam logic [19:0] VID_HI         = 20'hBFFFF;
    localparam logic [19:0] ASEG_HI        = 20'hAFFFF;
    localparam logic [19:0] MONO_LO        = 20'hB0000;
    localparam logic [19:0] MONO_HI        = 20'hB7FFF;
    localparam logic [19:0] CTXT_LO        = 20'hB8000;
    localparam logic [19:0] SEG_BASE       = 20'hC0000;
    localparam logic [19:0] SEG_SPAN       = 20'h10000;
    localparam int          SEG_NUM        = 4;
    localparam logic [19:0] CD_LO          = 20'hDC000;
    localparam logic [19:0] CD_HI          = 20'hDFFFF;

    // Result latency in clock cycles
    localparam int          RSP_LAT        = 1;

    typedef enum logic [4:0] {
        RT_DRAM  = 5'h01,
        RT_HUB   = 5'h02,
        RT_GFX   = 5'h04,
        RT_ABORT = 5'h08,
        RT_EXT   = 5'h10
    } lad_route_t;

    typedef enum logic [3:0] {
        GT_NONE   = 4'h1,
        GT_VGA    = 4'h2,
        GT_DCACHE = 4'h4,
        GT_MMAP   = 4'h8
    } lad_gtgt_t;

endpackage

// >>> logic/lad_range_hit.sv
`timescale 1ns/1ps
module lad_range_hit #(
    parameter logic [19:0] LO = 20'h00000,
    parameter logic [19:0] HI = 20'hFFFFF
) (
    // Address under test
    input  wire logic        en_i,
    input  wire logic [19:0] addr_i,
    // Result
    output logic             hit_o
);
    assign hit_o = en_i && (addr_i >= LO) && (addr_i <= HI);
endmodule // lad_range_hit

// >>> logic/lad_vga_regs.sv
`timescale 1ns/1ps
module lad_vga_regs (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    // Port access
    input  wire logic        io_wr_i,
    input  wire logic        io_rd_i,
    input  wire logic [15:0] io_port_i,
    input  wire logic [7:0]  io_wdata_i,
    output logic      [7:0]  io_rdata_o,
    output logic             io_rvalid_o,
    // Decoder configuration
    lad_cfg_if.src           cfg
);
    typedef struct packed {
        logic [lad_pkg::IDX_W-1:0] idx;
        logic [1:0]                mode;
        logic [lad_pkg::AM_W-1:0]  amap;
        logic [7:0]                page;
        logic                      legacy;
        logic [7:0]                rdata;
        logic                      rvalid;
    } lad_reg_st_t;

    lad_reg_st_t st_q;
    lad_reg_st_t st_d;

    // A write wins over a read in the same cycle
    always_comb begin
        st_d        = st_q;
        st_d.rvalid = 1'b0;
        if (io_wr_i) begin
            if (io_port_i == lad_pkg::IO_GFX_INDEX) begin
                st_d.idx = io_wdata_i[lad_pkg::IDX_W-1:0];
            end else if (io_port_i == lad_pkg::IO_GFX_DATA) begin
                if (st_q.idx == lad_pkg::IDX_MISC) begin
                    st_d.mode = io_wdata_i[lad_pkg::MISC_MODE_LSB +: 2];
                end else if (st_q.idx == lad_pkg::IDX_ADDR_MAP) begin
                    st_d.amap = io_wdata_i[lad_pkg::AM_W-1:0];
                end else if (st_q.idx == lad_pkg::IDX_PAGE) begin
                    st_d.page = io_wdata_i;
                end
            end else if (io_port_i == lad_pkg::IO_MISC_WR) begin
                st_d.legacy = io_wdata_i[lad_pkg::LEGACY_EN_BIT];
            end
        end else if (io_rd_i) begin
            st_d.rvalid = 1'b1;
            st_d.rdata  = 8'h00;
            if (io_port_i == lad_pkg::IO_GFX_INDEX) begin
                st_d.rdata[lad_pkg::IDX_READ_W-1:0] =
                    st_q.idx[lad_pkg::IDX_READ_W-1:0];
            end else if (io_port_i == lad_pkg::IO_GFX_DATA) begin
                if (st_q.idx == lad_pkg::IDX_MISC) begin
                    st_d.rdata[lad_pkg::MISC_MODE_LSB +: 2] = st_q.mode;
                end else if (st_q.idx == lad_pkg::IDX_ADDR_MAP) begin
                    st_d.rdata[lad_pkg::AM_W-1:0] = st_q.amap;
                end else if (st_q.idx == lad_pkg::IDX_PAGE) begin
                    st_d.rdata = st_q.page;
                end
            end else if (io_port_i == lad_pkg::IO_MISC_RD) begin
                st_d.rdata[lad_pkg::LEGACY_EN_BIT] = st_q.legacy;
            end else begin
                st_d.rvalid = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_q        <= '0;
            st_q.idx    <= lad_pkg::IDX_RST;
            st_q.mode   <= lad_pkg::MODE_RST;
            st_q.amap   <= lad_pkg::AM_RST;
            st_q.page   <= lad_pkg::PAGE_RST;
            st_q.legacy <= lad_pkg::LEGACY_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign io_rdata_o    = st_q.rdata;
    assign io_rvalid_o   = st_q.rvalid;
    assign cfg.map_mode  = st_q.mode;
    assign cfg.addr_map  = st_q.amap;
    assign cfg.page_sel  = st_q.page;
    assign cfg.legacy_en = st_q.legacy;
endmodule // lad_vga_regs
